// ---- odscl_fifo.sv ----
// frame fifo between the serial front end and the command executor
`timescale 1ns/10ps
module odscl_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic in_valid, // producer offers a word
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word offered
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // consumer takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);

  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer arithmetic cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("odscl_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // storage array
  always_ff @(posedge clock)
  begin
    if (do_wr)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : odscl_fifo

// ---- odscl_host.sv ----
// host serial controller model driving the frame pins
`timescale 1ns/10ps
module odscl_host (
  input wire logic clock, // system clock
  input wire logic serial_out, // data back from the block
  output logic sync_n, // frame select
  output logic sclk, // serial clock
  output logic serial_in // serial data
);
  ////////////////////////////////////////
  // idle levels from time zero
  initial
  begin
    sync_n = 1'h1;
    sclk = 1'h1;
    serial_in = 1'h0;
  end
  ////////////////////////////////////////
  // one frame of n bits; serial out sampled before each rise
  // msb first, data before fall
  task automatic frame(input logic [47:0] word, input int n, output logic [47:0] cap);
    cap = 48'h0;
    sync_n = 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = word[i];
      repeat (4) @(negedge clock);
      sclk = 1'h0;
      repeat (4) @(negedge clock);
      cap = {cap[46:0], serial_out};
      sclk = 1'h1;
    end
    repeat (4) @(negedge clock);
    sync_n = 1'h1;
    serial_in = ~serial_in; // released data line flips
    repeat (4) @(negedge clock);
    // stray clock pulse while deselected must be ignored
    sclk = 1'h0;
    repeat (4) @(negedge clock);
    sclk = 1'h1;
    repeat (4) @(negedge clock);
  endtask : frame
endmodule : odscl_host

// ---- odscl_pkg.sv ----
// constants shared by the octal converter serial command logic
package odscl_pkg;

  // frame layout
  localparam int FRAME_W = 24;
  localparam int CMD_POS = 20;
  localparam int ADDR_POS = 16;
  localparam int DATA_POS = 0;
  localparam int CODE_BITS = 16;
  localparam int NUM_CHANNELS = 8;
  localparam int CNT_W = 8;

  // command codes
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE_OUTPUT = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_POWER_MODE = 4'h4;
  localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
  localparam logic [3:0] CMD_CHAIN_SETUP = 4'h8;
  localparam logic [3:0] CMD_READBACK = 4'h9;

  // field positions inside the data word
  localparam int CHAIN_BIT_POS = 0;
  localparam int MASK_POS = 0;
  localparam int POWER_POS = 0;

  // pin vector positions and idle levels {load_outputs_n, sclk, serial_in, sync_n}
  localparam int PIN_SYNC = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_LOAD = 3;
  localparam logic [3:0] PIN_IDLE = 4'hD;

  // power mode pair encodings
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_GROUND = 2'h1;
  localparam logic [1:0] PM_RESERVED = 2'h2;
  localparam logic [1:0] PM_THREE_STATE = 2'h3;

  // values after reset, and the readback pad byte
  localparam logic RST_CHAIN_ENABLE = 1'b0;
  localparam logic [15:0] RST_POWER_MODES = 16'h0000;
  localparam logic [7:0] RST_LOAD_MASK = 8'h00;
  localparam logic [15:0] RST_CODE = 16'h0000;
  localparam logic [7:0] RB_PAD = 8'h00;

endpackage : odscl_pkg

// ---- odscl_properties.sv ----
// concurrent checks on the serial command logic ports
`timescale 1ns/10ps
module odscl_properties #(
  parameter int CHANNELS = 8,
  parameter int CODE_W = 16
) (
  input wire logic clock, // system clock
  input wire logic rst, // sync reset
  input wire logic sync_n, // frame select
  input wire logic sclk, // serial clock
  input wire logic load_outputs_n, // load pin
  input wire logic serial_out, // serial out level
  input wire logic serial_out_oe_n, // strong drive, low
  input wire logic serial_out_keep, // keeper holds
  input wire logic chain_enable, // chain mode
  input wire logic [15:0] channel_power_modes, // power pairs
  input wire logic [CHANNELS*CODE_W-1:0] output_codes, // output banks
  input wire logic [CHANNELS-1:0] chan_tied_ground, // ground tie
  input wire logic [CHANNELS-1:0] chan_three_state // three-state
);
  logic [CHANNELS-1:0] pair_ts;
  logic [CHANNELS-1:0] pair_gnd;
  ////////////////////////////////////////
  // pair decode expected from the mode bits
  always_comb
  begin
    for (int n = 0; n < CHANNELS; n++)
    begin
      pair_ts[n] = channel_power_modes[2*n+1] & channel_power_modes[2*n];
      pair_gnd[n] = channel_power_modes[2*n+1] ^ channel_power_modes[2*n];
    end
  end
  ////////////////////////////////////////
  // frame select idle, alone and with the load pin idle too
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_frame_idle;
    sync_n [*8];
  endsequence
  sequence s_quiet;
    (sync_n && load_outputs_n) [*8];
  endsequence
  AST_RST_DEFAULTS: assert property (disable iff (1'h0) rst |=> !chain_enable && channel_power_modes == 16'h0000)
    else $error("settings not cleared by reset");
  AST_KEEP_IDLE: assert property (s_frame_idle |-> serial_out_keep && serial_out_oe_n)
    else $error("serial out not on keeper between frames");
  AST_KEEP_STABLE: assert property (serial_out_keep && $past(serial_out_keep) |-> $stable(serial_out))
    else $error("kept serial out moved");
  AST_SO_ON_RISE: assert property ($changed(serial_out) && !sync_n && !$past(sync_n, 12)
    |-> $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5))
    else $error("serial out changed away from clock rise");
  AST_SCLK_IGNORED: assert property (s_quiet |-> ##3 $stable(output_codes))
    else $error("output banks moved outside a frame");
  AST_PM_THREE: assert property (chan_three_state == $past(pair_ts))
    else $error("three-state decode wrong");
  AST_PM_GROUND: assert property (chan_tied_ground == $past(pair_gnd))
    else $error("ground tie decode wrong");
  AST_CHAIN_AFTER_FRAME: assert property ($changed(chain_enable) |-> sync_n && $past(sync_n, 5))
    else $error("chain mode changed inside a frame");
  AST_POWER_AFTER_FRAME: assert property ($changed(channel_power_modes) |-> sync_n && $past(sync_n, 5))
    else $error("power modes changed inside a frame");
endmodule : odscl_properties

bind odscl_top odscl_properties #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) odscl_properties_i (.clock(clock),
  .rst(rst), .sync_n(sync_n), .sclk(sclk), .load_outputs_n(load_outputs_n), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .serial_out_keep(serial_out_keep), .chain_enable(chain_enable),
  .channel_power_modes(channel_power_modes), .output_codes(output_codes), .chan_tied_ground(chan_tied_ground),
  .chan_three_state(chan_three_state));

// ---- odscl_top.sv ----
// serial command logic of an eight channel converter: shifter, registers, chain, readback, power modes
// What this block does
// - command 0001 writes input registers; low unmasked load pin makes them transparent
// - command 0010 copies addressed input register into output register
// - command 0011 writes addressed output registers directly, load pin ignored
// - for 0011, data bits 7..0 set copy that channel's input to output
// - command 1000 loads chain enable from data bit 0; standalone after reset
// - in chain mode, bits beyond 24 leave on serial out, changing on rising clock
// - a frame ended at any nonzero clock count still executes
// - frame select rising latches the word; clocks ignored until it falls
// - command 1001 selects one channel by address for readback; rest ignored
// - serial out enabled for a read frame even when chain mode is off
// - read frame shifts 24 bits; last 16 carry the selected register
// - while frame select high, serial out held weakly at last bit
// - command 0100 loads two power bits per channel from data 15..0
// - power pair 00 normal, 01 tied to ground, 11 three-state
// - power down keeps output registers; they still accept updates
// - two register banks per channel; load pin governs input to output
// - load pin low during 0001 updates input and output registers
// - frame is 24 bits msb first: command, address, data word
// - serial in sampled on falling serial clock while frame select low
// - load pin falling copies input to output for unmasked channels
// - channels with mask bit set ignore the load pin
`timescale 1ns/10ps
module odscl_top #(
  parameter int CHANNELS = 8,
  parameter int CODE_W = 16,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock, // system clock, 50 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic sync_n, // frame select pin, active low
  input wire logic sclk, // serial clock pin
  input wire logic serial_in, // serial data pin
  input wire logic load_outputs_n, // load pin, active low
  output logic serial_out, // serial data out level
  output logic serial_out_oe_n, // low while serial out is driven strongly
  output logic serial_out_keep, // high while the weak keeper holds serial out
  output logic chain_enable, // chain mode setting
  output logic [15:0] channel_power_modes, // two power bits per channel
  output logic [CHANNELS*CODE_W-1:0] output_codes, // output registers, channel 0 lowest
  output logic [CHANNELS-1:0] chan_tied_ground, // channel output tied to ground
  output logic [CHANNELS-1:0] chan_three_state, // channel output three-stated
  output logic frame_overflow // sticky: a frame found the fifo full
);

  // the frame format fixes eight 16 bit channels
  if (CHANNELS != odscl_pkg::NUM_CHANNELS || CODE_W != odscl_pkg::CODE_BITS || FIFO_DEPTH < 2)
  begin : g_bad_param
    $error("odscl_top: only eight 16 bit channels and a fifo of two or more words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one-hot channel select from the address field
  function automatic logic [7:0] addr_sel(input logic [3:0] a);
    addr_sel = a[3] ? 8'h00 : (8'h01 << a[2:0]);
  endfunction : addr_sel

  // power pair of one channel
  function automatic logic [1:0] pm_pair(input logic [15:0] pm, input int ch);
    pm_pair = pm[2*ch +: 2];
  endfunction : pm_pair

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_lvl;
  logic [3:0] pin_lvl_d;

  // three flops; a level counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_s1 <= odscl_pkg::PIN_IDLE;
      pin_s2 <= odscl_pkg::PIN_IDLE;
      pin_s3 <= odscl_pkg::PIN_IDLE;
      pin_lvl <= odscl_pkg::PIN_IDLE;
      pin_lvl_d <= odscl_pkg::PIN_IDLE;
    end
    else
    begin
      pin_s1 <= {load_outputs_n, sclk, serial_in, sync_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
      pin_lvl_d <= pin_lvl;
    end
  end

  logic in_frame;
  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic load_low;
  logic load_fall;

  // edge events of the filtered pins
  assign in_frame = !pin_lvl[odscl_pkg::PIN_SYNC];
  assign sync_fall = pin_lvl_d[odscl_pkg::PIN_SYNC] && !pin_lvl[odscl_pkg::PIN_SYNC];
  assign sync_rise = !pin_lvl_d[odscl_pkg::PIN_SYNC] && pin_lvl[odscl_pkg::PIN_SYNC];
  assign sclk_fall = pin_lvl_d[odscl_pkg::PIN_SCLK] && !pin_lvl[odscl_pkg::PIN_SCLK];
  assign sclk_rise = !pin_lvl_d[odscl_pkg::PIN_SCLK] && pin_lvl[odscl_pkg::PIN_SCLK];
  assign load_low = !pin_lvl[odscl_pkg::PIN_LOAD];
  assign load_fall = pin_lvl_d[odscl_pkg::PIN_LOAD] && !pin_lvl[odscl_pkg::PIN_LOAD];

  ////////////////////////////////////////////////////////////////////////////
  // input shift register

  logic [odscl_pkg::FRAME_W-1:0] shift_reg;
  logic [odscl_pkg::CNT_W-1:0] bit_cnt;
  logic rb_pending;
  logic read_frame;
  logic [2:0] rb_chan;
  logic [CODE_W-1:0] input_reg [CHANNELS];
  logic [odscl_pkg::FRAME_W-1:0] rb_word;

  assign rb_word = {odscl_pkg::RB_PAD, input_reg[rb_chan]};

  // clocks outside a frame are ignored
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shift_reg <= '0;
      bit_cnt <= '0;
    end
    else if (sync_fall)
    begin
      bit_cnt <= '0;
      if (rb_pending)
      begin
        shift_reg <= rb_word;
      end
    end
    else if (in_frame && sclk_fall)
    begin
      shift_reg <= {shift_reg[odscl_pkg::FRAME_W-2:0], pin_lvl[odscl_pkg::PIN_SDI]};
      if (bit_cnt != '1)
      begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output

  // next bit appears on each rising clock
  // read frame presents the readback word from its first bit
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      serial_out <= 1'b0;
    end
    else if (sync_fall)
    begin
      serial_out <= rb_pending ? rb_word[odscl_pkg::FRAME_W-1] : shift_reg[odscl_pkg::FRAME_W-1];
    end
    else if (in_frame && sclk_rise)
    begin
      serial_out <= shift_reg[odscl_pkg::FRAME_W-1];
    end
  end

  // read frame forces the driver on
  // keeper holds the last bit outside a frame
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      serial_out_oe_n <= 1'b1;
      serial_out_keep <= 1'b1;
    end
    else
    begin
      serial_out_oe_n <= !(in_frame && (chain_enable || read_frame));
      serial_out_keep <= !in_frame;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame fifo and executor handshake

  logic frame_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [odscl_pkg::FRAME_W-1:0] fifo_out_data;

  assign frame_push = sync_rise && (bit_cnt != '0);
  // a load pin edge takes the register file for one cycle
  assign fifo_out_ready = !load_fall;

  odscl_fifo #(
    .WIDTH(odscl_pkg::FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(frame_push),
    .in_ready(fifo_in_ready),
    .in_data(shift_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // lost frame flag, cleared only by reset
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      frame_overflow <= 1'b0;
    end
    else if (frame_push && !fifo_in_ready)
    begin
      frame_overflow <= 1'b1;
    end
  end

  logic take;
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [CODE_W-1:0] data;
  logic [7:0] sel;
  logic soft_rst;

  // field split of the latched word
  assign take = fifo_out_valid && fifo_out_ready;
  assign cmd = fifo_out_data[odscl_pkg::CMD_POS +: 4];
  assign addr = fifo_out_data[odscl_pkg::ADDR_POS +: 4];
  assign data = fifo_out_data[odscl_pkg::DATA_POS +: CODE_W];
  assign sel = addr_sel(addr);
  assign soft_rst = take && (cmd == odscl_pkg::CMD_SOFT_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // control settings

  logic [7:0] load_mask;

  // chain, mask and power mode settings
  always_ff @(posedge clock)
  begin
    if (rst || soft_rst)
    begin
      chain_enable <= odscl_pkg::RST_CHAIN_ENABLE;
      load_mask <= odscl_pkg::RST_LOAD_MASK;
      channel_power_modes <= odscl_pkg::RST_POWER_MODES;
    end
    else if (take)
    begin
      case (cmd)
        odscl_pkg::CMD_CHAIN_SETUP: chain_enable <= data[odscl_pkg::CHAIN_BIT_POS];
        odscl_pkg::CMD_LOAD_MASK: load_mask <= data[odscl_pkg::MASK_POS +: 8];
        // two bits per channel from data 15..0
        odscl_pkg::CMD_POWER_MODE: channel_power_modes <= data[odscl_pkg::POWER_POS +: 16];
        default: chain_enable <= chain_enable;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chan_tied_ground <= '0;
      chan_three_state <= '0;
    end
    else
    begin
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        chan_tied_ground[ch] <= (pm_pair(channel_power_modes, ch) == odscl_pkg::PM_GROUND) ||
                                (pm_pair(channel_power_modes, ch) == odscl_pkg::PM_RESERVED);
        chan_three_state[ch] <= (pm_pair(channel_power_modes, ch) == odscl_pkg::PM_THREE_STATE);
      end
    end
  end

  // readback channel select, one frame pending
  always_ff @(posedge clock)
  begin
    if (rst || soft_rst)
    begin
      rb_pending <= 1'b0;
      read_frame <= 1'b0;
      rb_chan <= 3'h0;
    end
    else
    begin
      if (take && cmd == odscl_pkg::CMD_READBACK)
      begin
        rb_pending <= 1'b1;
        rb_chan <= addr[2:0];
      end
      else if (sync_fall)
      begin
        rb_pending <= 1'b0;
      end
      if (sync_fall)
      begin
        read_frame <= rb_pending;
      end
      else if (sync_rise)
      begin
        read_frame <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register banks

  always_ff @(posedge clock)
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (rst || soft_rst)
      begin
        input_reg[ch] <= odscl_pkg::RST_CODE;
      end
      else if (take && sel[ch] && (cmd == odscl_pkg::CMD_WRITE_INPUT || cmd == odscl_pkg::CMD_WRITE_UPDATE))
      begin
        input_reg[ch] <= data;
      end
    end
  end

  // output bank; power modes never touch it
  // updates regardless of power mode
  always_ff @(posedge clock)
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (rst || soft_rst)
      begin
        output_codes[ch*CODE_W +: CODE_W] <= odscl_pkg::RST_CODE;
      end
      else if (take && sel[ch] && cmd == odscl_pkg::CMD_WRITE_UPDATE)
      begin
        output_codes[ch*CODE_W +: CODE_W] <= data;
      end
      // load low makes 0001 update both banks
      else if (take && sel[ch] && cmd == odscl_pkg::CMD_WRITE_INPUT && load_low && !load_mask[ch])
      begin
        output_codes[ch*CODE_W +: CODE_W] <= data;
      end
      else if (take && sel[ch] && cmd == odscl_pkg::CMD_UPDATE_OUTPUT)
      begin
        output_codes[ch*CODE_W +: CODE_W] <= input_reg[ch];
      end
      // data bit set copies input to output
      else if (take && data[ch] && cmd == odscl_pkg::CMD_WRITE_UPDATE)
      begin
        output_codes[ch*CODE_W +: CODE_W] <= input_reg[ch];
      end
      // load falling or held low copies input
      // masked channels ignore the load pin
      else if ((load_fall || load_low) && !load_mask[ch])
      begin
        output_codes[ch*CODE_W +: CODE_W] <= input_reg[ch];
      end
    end
  end

endmodule : odscl_top

// ---- tb.sv ----
// self-checking bench for the serial command logic
`timescale 1ns/10ps
module tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic load_outputs_n = 1'h1;
  logic sync_n, sclk, serial_in, serial_out, serial_out_oe_n, serial_out_keep, chain_enable, frame_overflow;
  logic [15:0] channel_power_modes;
  logic [127:0] output_codes;
  logic [7:0] chan_tied_ground, chan_three_state;
  logic [47:0] cap;
  logic [23:0] shift = 24'h0;
  logic [31:0] r;
  logic oe_seen = 1'h0;
  logic [3:0] cmds [4] = '{4'h3, 4'h1, 4'h2, 4'h4};
  int fail_count = 0;
  int checked = 0;
  int seed = 32'hC3659C27;
  int in_reg [8] = '{default: 0};
  int out_reg [8] = '{default: 0};
  int pm = 0;
  int mask = 0;
  int chain = 0;
  int rd = 0;
  int rd_ch = 0;
  ////////////////////////////////////////
  // clock, design and host
  always #10 clock = ~clock;
  odscl_top odscl_top_i (.clock(clock), .rst(rst), .sync_n(sync_n), .sclk(sclk), .serial_in(serial_in),
    .load_outputs_n(load_outputs_n), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .serial_out_keep(serial_out_keep), .chain_enable(chain_enable), .channel_power_modes(channel_power_modes),
    .output_codes(output_codes), .chan_tied_ground(chan_tied_ground), .chan_three_state(chan_three_state),
    .frame_overflow(frame_overflow));
  odscl_host odscl_host_i (.clock(clock), .serial_out(serial_out), .sync_n(sync_n), .sclk(sclk),
    .serial_in(serial_in));
  // note any strong drive of serial out
  always @(posedge clock)
    if (!serial_out_oe_n)
      oe_seen <= 1'h1;
  ////////////////////////////////////////
  // compare and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // model of the values after any reset
  task automatic model_reset();
    in_reg = '{default: 0};
    out_reg = '{default: 0};
    pm = 0;
    chain = 0;
    mask = 0;
    rd = 0;
  endtask : model_reset
  // model of one executed word
  task automatic exec(input logic [23:0] w);
    int a;
    a = w[19:16];
    if (w[23:20] == 4'h1 && a < 8)
    begin
      in_reg[a] = w[15:0];
      if (!load_outputs_n && !mask[a])
        out_reg[a] = w[15:0];
    end
    if (w[23:20] == 4'h5)
      mask = w[7:0];
    if (w[23:20] == 4'h6)
      model_reset();
    if (w[23:20] == 4'h2 && a < 8)
      out_reg[a] = in_reg[a];
    if (w[23:20] == 4'h3)
    begin
      if (a < 8)
      begin
        in_reg[a] = w[15:0];
        out_reg[a] = w[15:0];
      end
      for (int n = 0; n < 8; n++)
        if (w[n])
          out_reg[n] = in_reg[n];
    end
    if (w[23:20] == 4'h4)
      pm = w[15:0];
    if (w[23:20] == 4'h8)
      chain = w[0];
    if (w[23:20] == 4'h9)
    begin
      rd = 1;
      rd_ch = a;
    end
  endtask : exec
  task automatic check_all();
    logic [7:0] g;
    logic [7:0] t;
    for (int n = 0; n < 8; n++)
    begin
      check(output_codes[16*n+:16], out_reg[n]);
      g[n] = pm[2*n+:2] inside {2'h1, 2'h2};
      t[n] = pm[2*n+:2] == 2'h3;
    end
    check(channel_power_modes, pm);
    check(chan_tied_ground, g);
    check(chan_three_state, t);
    check(chain_enable, chain);
    check(frame_overflow, 0);
  endtask : check_all
  // one frame through the host, then model and compare
  task automatic send(input logic [47:0] w, input int n);
    logic [47:0] want;
    int live;
    want = 48'h0;
    live = chain | rd;
    if (rd)
      shift = {8'h00, in_reg[rd_ch][15:0]};
    rd = 0;
    for (int i = n - 1; i >= 0; i--)
    begin
      want = {want[46:0], shift[23]};
      shift = {shift[22:0], w[i]};
    end
    oe_seen = 1'h0;
    odscl_host_i.frame(w, n, cap);
    repeat (6) @(negedge clock);
    exec(shift);
    check(oe_seen, live);
    if (live)
    begin
      check(cap[23:0], want[23:0]);
      check(cap[47:24], want[47:24]);
    end
    check_all();
  endtask : send
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(negedge clock);
    rst = 1'h0;
    @(negedge clock);
    check_all();
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      send({cmds[i % 4], ((i == 5) ? 4'h9 : {1'h0, r[18:16]}), r[15:0]}, 24);
    end
    for (int k = 0; k < 2; k++)
    begin
      load_outputs_n = 1'h0;
      repeat (6) @(negedge clock);
      for (int n = 0; n < 8; n++)
        out_reg[n] = in_reg[n];
      if (k == 0)
        send({8'h12, r[15:0]}, 24);
      load_outputs_n = 1'h1;
      repeat (6) @(negedge clock);
      if (k == 0)
        send(24'h135A5A, 24);
    end
    check_all();
    send(24'h800001, 24);
    send({r[23:0], 24'h311350}, 48);
    send(48'hBEE, 12);
    send(24'h800000, 24);
    for (int k = 0; k < 3; k++)
    begin
      r = $random(seed);
      send({5'h12, r[2:0], 16'hFFFF}, 24);
      send(24'h000000, 24);
    end
    // masked channels keep their outputs through a load pulse
    send(24'h500055, 24);
    for (int n = 0; n < 2; n++)
      send({4'h1, 4'(n), r[15:0]}, 24);
    load_outputs_n = 1'h0;
    repeat (6) @(negedge clock);
    for (int n = 0; n < 8; n++)
      if (!mask[n])
        out_reg[n] = in_reg[n];
    load_outputs_n = 1'h1;
    repeat (6) @(negedge clock);
    check_all();
    // reset in mid-run, then a frame, then the soft reset command
    rst = 1'h1;
    repeat (2) @(negedge clock);
    rst = 1'h0;
    model_reset();
    shift = 24'h0;
    @(negedge clock);
    check_all();
    r = $random(seed);
    send({8'h37, r[15:0]}, 24);
    send(24'h600000, 24);
    results();
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    fail_count++;
    results();
  end
endmodule : tb
